// >>> rtl/pwc_cfg.svh
// pwc_cfg.svh: offsets, bit positions, reset values and timing counts
// assumes: included by bare name from the package and the bench
`ifndef PWC_CFG_SVH
`define PWC_CFG_SVH

// process image geometry
`define PWC_IMG_BYTES 8
`define PWC_MIN_BYTES 6
`define PWC_CH1_CTRL_PACKED 0
`define PWC_CH1_DATA_PACKED 1
`define PWC_CH2_CTRL_PACKED 3
`define PWC_CH2_DATA_PACKED 4
`define PWC_CH1_CTRL_ALIGNED 0
`define PWC_CH1_DATA_ALIGNED 2
`define PWC_CH2_CTRL_ALIGNED 4
`define PWC_CH2_DATA_ALIGNED 6

// control byte bit positions
`define PWC_CB_REG_MODE 7
`define PWC_CB_ERR_CLEAR 6
`define PWC_CB_ENABLE 5
`define PWC_CB_LATCH_VIEW 4
`define PWC_CB_FALL_ARM 3
`define PWC_CB_RISE_ARM 2
`define PWC_CB_PRESET 1
`define PWC_CB_DITHER 0

// output word scaling
`define PWC_FULL_SCALE 16'sh7fff
`define PWC_NEG_LIMIT 16'sh8001

// reset values
`define PWC_CTRL_RESET 8'h00
`define PWC_WORD_RESET 16'h0000
`define PWC_CFG_RESET 3'h0

// exchange cycle timing
`define PWC_CLK_PERIOD_PS 8000
`define PWC_CYCLE_NS 10000
`define PWC_CYCLE_CLKS ((`PWC_CYCLE_NS * 1000) / `PWC_CLK_PERIOD_PS)

// coupler register map, byte addresses
`define PWC_REG_CTRL1 8'h00
`define PWC_REG_OUT1 8'h04
`define PWC_REG_CTRL2 8'h08
`define PWC_REG_OUT2 8'h0c
`define PWC_REG_STAT1 8'h10
`define PWC_REG_IN1 8'h14
`define PWC_REG_STAT2 8'h18
`define PWC_REG_IN2 8'h1c
`define PWC_REG_CFG 8'h20
`define PWC_REG_COUNT 8'h24
`define PWC_CFG_ALIGN 0
`define PWC_CFG_OUT_ONLY 1
`define PWC_CFG_RUN 2

`endif

// >>> rtl/pwc_coupler.sv
// pwc_coupler: fieldbus coupler end, cyclic exchange of the process image
// assumes: software drives an Avalon-MM slave with waitrequest on clk
`timescale 1ns/1ps
module pwc_coupler import pwc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // software port
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // process image
  pwc_if.coupler link
);

  logic [1:0][7:0] ctrl;
  logic [1:0][15:0] out_word;
  logic [1:0][7:0] stat;
  logic [1:0][15:0] in_word;
  logic [2:0] cfg;
  logic [15:0] count;
  logic [15:0] tick_cnt;
  pwc_state_t state;
  pwc_state_t next_state;

  // one wait state per access; the access completes when waitrequest is low
  wire req = avs_read || avs_write;
  wire take = req && !avs_waitrequest;
  wire sel_ctrl1 = avs_address == `PWC_REG_CTRL1;
  wire sel_out1 = avs_address == `PWC_REG_OUT1;
  wire sel_ctrl2 = avs_address == `PWC_REG_CTRL2;
  wire sel_out2 = avs_address == `PWC_REG_OUT2;
  wire sel_cfg = avs_address == `PWC_REG_CFG;
  wire wr = take && avs_write;
  wire [31:0] rd_mux =
    (sel_ctrl1) ? {24'h000000, ctrl[0]} :
    (sel_out1) ? {16'h0000, out_word[0]} :
    (sel_ctrl2) ? {24'h000000, ctrl[1]} :
    (sel_out2) ? {16'h0000, out_word[1]} :
    (avs_address == `PWC_REG_STAT1) ? {24'h000000, stat[0]} :
    (avs_address == `PWC_REG_IN1) ? {16'h0000, in_word[0]} :
    (avs_address == `PWC_REG_STAT2) ? {24'h000000, stat[1]} :
    (avs_address == `PWC_REG_IN2) ? {16'h0000, in_word[1]} :
    (sel_cfg) ? {29'h00000000, cfg} :
    (avs_address == `PWC_REG_COUNT) ? {16'h0000, count} : 32'h00000000;
  wire [15:0] wr_lo = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00, avs_writedata[7:0]};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // byte lane 0 must be enabled; lane 1 extends the data words
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= {2{`PWC_CTRL_RESET}};
      out_word <= {2{`PWC_WORD_RESET}};
      cfg <= `PWC_CFG_RESET;
    end else if (wr && avs_byteenable[0]) begin
      if (sel_ctrl1) ctrl[0] <= avs_writedata[7:0];
      if (sel_ctrl2) ctrl[1] <= avs_writedata[7:0];
      if (sel_out1) out_word[0] <= wr_lo;
      if (sel_out2) out_word[1] <= wr_lo;
      if (sel_cfg) cfg <= avs_writedata[2:0];
    end
  end

  // exchange timer
  wire tick = tick_cnt == 16'(`PWC_CYCLE_CLKS - 1);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      PWC_IDLE: if (tick && cfg[`PWC_CFG_RUN]) next_state = PWC_SEND;
      PWC_SEND: next_state = PWC_WAIT;
      PWC_WAIT: if (link.in_done) next_state = PWC_IDLE;
      default: next_state = PWC_IDLE;
    endcase
  end

  // items go on even addresses when aligned control bytes always sent
  pwc_image_t next_out_img;
  always_comb begin
    next_out_img = '0;
    if (cfg[`PWC_CFG_ALIGN]) begin
      next_out_img[8*`PWC_CH1_CTRL_ALIGNED +: 8] = ctrl[0];
      next_out_img[8*`PWC_CH1_DATA_ALIGNED +: 16] = out_word[0];
      next_out_img[8*`PWC_CH2_CTRL_ALIGNED +: 8] = ctrl[1];
      next_out_img[8*`PWC_CH2_DATA_ALIGNED +: 16] = out_word[1];
    end else begin
      next_out_img[8*`PWC_CH1_CTRL_PACKED +: 8] = ctrl[0];
      next_out_img[8*`PWC_CH1_DATA_PACKED +: 16] = out_word[0];
      next_out_img[8*`PWC_CH2_CTRL_PACKED +: 8] = ctrl[1];
      next_out_img[8*`PWC_CH2_DATA_PACKED +: 16] = out_word[1];
    end
  end

  // the answer is unpacked with the layout that went out, not a cfg written meanwhile
  wire [3:0] s2 = link.word_align ? 4'(`PWC_CH2_CTRL_ALIGNED) : 4'(`PWC_CH2_CTRL_PACKED);
  wire [3:0] d1 = link.word_align ? 4'(`PWC_CH1_DATA_ALIGNED) : 4'(`PWC_CH1_DATA_PACKED);
  wire [3:0] d2 = link.word_align ? 4'(`PWC_CH2_DATA_ALIGNED) : 4'(`PWC_CH2_DATA_PACKED);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= PWC_IDLE;
      link.xfer <= 1'b0;
      link.out_img <= '0;
      link.word_align <= 1'b0;
      link.out_only <= 1'b0;
      stat <= 16'h0000;
      in_word <= 32'h00000000;
      count <= 16'h0000;
    end else begin
      state <= next_state;
      link.xfer <= next_state == PWC_SEND;
      // form bits change only with a new image, so one exchange never mixes two layouts
      if (next_state == PWC_SEND) begin
        link.out_img <= next_out_img;
        link.word_align <= cfg[`PWC_CFG_ALIGN];
        link.out_only <= cfg[`PWC_CFG_OUT_ONLY];
      end
      if (state == PWC_WAIT && link.in_done) begin
        count <= count + 16'h0001;
        if (!link.out_only) begin
          stat[0] <= link.in_img[7:0];
          stat[1] <= link.in_img[8*s2 +: 8];
          in_word[0] <= link.in_img[8*d1 +: 16];
          in_word[1] <= link.in_img[8*d2 +: 16];
        end
      end
    end
  end

endmodule // pwc_coupler

// >>> rtl/pwc_if.sv
// pwc_if: cyclic process image between coupler and current unit
// assumes: one clock; the coupler starts each exchange, the unit answers
`timescale 1ns/1ps
interface pwc_if import pwc_pkg::*; ();
  logic xfer;
  logic word_align;
  logic out_only;
  pwc_image_t out_img;
  pwc_image_t in_img;
  logic in_done;

  modport unit (
    input xfer,
    input word_align,
    input out_only,
    input out_img,
    output in_img,
    output in_done
  );

  modport coupler (
    output xfer,
    output word_align,
    output out_only,
    output out_img,
    input in_img,
    input in_done
  );
endinterface

// >>> rtl/pwc_pkg.sv
// pwc_pkg: types shared by the unit, the coupler and the interface
// assumes: pwc_cfg.svh is on the include path
package pwc_pkg;
  `include "pwc_cfg.svh"

  typedef struct packed {
    logic register_mode_select;
    logic err_clear;
    logic enable;
    logic latch_view_select;
    logic falling_capture_arm;
    logic rising_capture_arm;
    logic position_preset_strobe;
    logic dither_on;
  } pwc_ctrl_t;

  typedef struct packed {
    logic register_mode;
    logic error;
    logic warning;
    logic ready;
    logic latch_view_ack;
    logic capture_valid;
    logic preset_done;
    logic aux_input_one;
  } pwc_stat_t;

  typedef logic [8*`PWC_IMG_BYTES-1:0] pwc_image_t;

  typedef enum logic [2:0] {
    PWC_IDLE = 3'h1,
    PWC_SEND = 3'h2,
    PWC_WAIT = 3'h4
  } pwc_state_t;
endpackage

// >>> rtl/pwc_unit.sv
// pwc_unit: two-channel current unit, process-data side of the image
// assumes: coupler drives the image per pwc_if; pins are asynchronous
//
// Behaviour
// - full image: six input and output bytes
// - per channel status/control byte then data word
// - coupler puts items on even addresses when aligned
// - output-only image: six output bytes, no input
// - control bytes always present, even compact
// - channel runs only with enable bit set
// - output word maps linearly to current
// - control travels out, status travels in
// - bit 7 low means process data mode
// - rising error-clear bit clears pending errors
// - latch view bit selects position or latch
// - falling arm captures position on falling edge
// - rising arm captures position on rising edge
// - rising arm wins when both arms set
// - rising preset bit loads position from preset
// - dither needs dither bit and feature bit
// - status byte bit layout as documented
// - channel two uses identical byte layouts
// - ready only when enabled and error-free
// - preset done acknowledges the preset strobe
// - bit 7 high selects register communication
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
module pwc_unit import pwc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // process image
  pwc_if.unit link,
  // field pins, asynchronous
  input wire logic [1:0] latch_pin,
  input wire logic [1:0] aux_pin,
  input wire logic [1:0] fault_pin,
  input wire logic [1:0] warn_pin,
  // position source on clk
  input wire logic [1:0] pos_step,
  input wire logic [1:0] pos_dir,
  // parameter values
  input wire logic [1:0][15:0] position_preset_register,
  input wire logic [15:0] max_current_setting,
  input wire logic dither_feature_bit,
  // drive outputs
  output logic signed [1:0][16:0] current_cmd,
  output logic [1:0] channel_on,
  output logic [1:0] dither_active
);

  // pin synchronisers
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [1:0] latch_prev;
  logic xfer_d;
  wire [7:0] pin_raw = {warn_pin, fault_pin, aux_pin, latch_pin};
  wire [1:0] latch_s = pin_sync[1:0];
  wire [1:0] aux_s = pin_sync[3:2];
  wire [1:0] fault_s = pin_sync[5:4];
  wire [1:0] warn_s = pin_sync[7:6];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      latch_prev <= 2'h0;
      xfer_d <= 1'b0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      latch_prev <= latch_s;
      xfer_d <= link.xfer;
    end
  end

  // byte placement, same layout for both channels
  wire [3:0] ctrl_off [2];
  wire [3:0] data_off [2];
  assign ctrl_off[0] = link.word_align ? 4'(`PWC_CH1_CTRL_ALIGNED) : 4'(`PWC_CH1_CTRL_PACKED);
  assign ctrl_off[1] = link.word_align ? 4'(`PWC_CH2_CTRL_ALIGNED) : 4'(`PWC_CH2_CTRL_PACKED);
  assign data_off[0] = link.word_align ? 4'(`PWC_CH1_DATA_ALIGNED) : 4'(`PWC_CH1_DATA_PACKED);
  assign data_off[1] = link.word_align ? 4'(`PWC_CH2_DATA_ALIGNED) : 4'(`PWC_CH2_DATA_PACKED);

  pwc_stat_t stat [2];
  logic [15:0] in_word [2];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      // per-channel state, identical for both channels
      pwc_ctrl_t ctrl;
      pwc_ctrl_t prev;
      logic err;
      logic valid;
      logic done;
      logic [15:0] pos;
      logic [15:0] latch_val;
      logic signed [15:0] out_word;

      // control byte travels in the output image
      wire pwc_ctrl_t rx_ctrl = pwc_ctrl_t'(link.out_img[8*ctrl_off[ch] +: 8]);
      wire [15:0] rx_word = link.out_img[8*data_off[ch] +: 16];
      wire process_cyc = link.xfer && !rx_ctrl.register_mode_select;
      wire clear_edge = process_cyc && rx_ctrl.err_clear && !prev.err_clear;
      wire preset_edge = process_cyc && rx_ctrl.position_preset_strobe && !prev.position_preset_strobe;
      wire rise_ev = latch_s[ch] && !latch_prev[ch];
      wire fall_ev = !latch_s[ch] && latch_prev[ch];
      // rising arm masks the falling arm entirely
      wire capture = ctrl.rising_capture_arm ? rise_ev : (ctrl.falling_capture_arm && fall_ev);
      wire enabled = ctrl.enable && !ctrl.register_mode_select;
      wire signed [15:0] clamped = (out_word == 16'sh8000) ? `PWC_NEG_LIMIT : out_word;
      wire signed [32:0] product = clamped * $signed({1'b0, max_current_setting});
      wire signed [32:0] scaled = product / 33'(`PWC_FULL_SCALE);

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          ctrl <= pwc_ctrl_t'(`PWC_CTRL_RESET);
          prev <= pwc_ctrl_t'(`PWC_CTRL_RESET);
          out_word <= `PWC_WORD_RESET;
        end else if (link.xfer) begin
          ctrl <= rx_ctrl;
          if (process_cyc) begin
            prev <= rx_ctrl;
            out_word <= rx_word;
          end
        end
      end

      // a fault arriving with the clear edge stays pending
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          err <= 1'b0;
        end else if (fault_s[ch]) begin
          err <= 1'b1;
        end else if (clear_edge) begin
          err <= 1'b0;
        end
      end

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          pos <= 16'h0000;
        end else if (preset_edge) begin
          pos <= position_preset_register[ch];
        end else if (pos_step[ch]) begin
          pos <= pos_dir[ch] ? pos + 16'h0001 : pos - 16'h0001;
        end
      end

      // capture stays valid until both arms are withdrawn
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          latch_val <= 16'h0000;
          valid <= 1'b0;
        end else if (capture) begin
          latch_val <= pos;
          valid <= 1'b1;
        end else if (link.xfer && !rx_ctrl.rising_capture_arm && !rx_ctrl.falling_capture_arm) begin
          valid <= 1'b0;
        end
      end

      // acknowledge stays until the strobe is dropped; cleared at that exchange so its answer already shows it
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          done <= 1'b0;
        end else if (preset_edge) begin
          done <= 1'b1;
        end else if (link.xfer && !rx_ctrl.position_preset_strobe) begin
          done <= 1'b0;
        end
      end

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          current_cmd[ch] <= 17'sh00000;
          channel_on[ch] <= 1'b0;
          dither_active[ch] <= 1'b0;
        end else begin
          current_cmd[ch] <= enabled ? scaled[16:0] : 17'sh00000;
          channel_on[ch] <= enabled;
          dither_active[ch] <= enabled && ctrl.dither_on && dither_feature_bit;
        end
      end

      // register mode leaves only its acknowledge in the status byte
      assign stat[ch].register_mode = ctrl.register_mode_select;
      assign stat[ch].error = !ctrl.register_mode_select && err;
      assign stat[ch].warning = !ctrl.register_mode_select && warn_s[ch];
      assign stat[ch].ready = enabled && !err;
      assign stat[ch].latch_view_ack = enabled && ctrl.latch_view_select && valid;
      assign stat[ch].capture_valid = !ctrl.register_mode_select && valid;
      assign stat[ch].preset_done = !ctrl.register_mode_select && done;
      assign stat[ch].aux_input_one = !ctrl.register_mode_select && aux_s[ch];
      assign in_word[ch] = ctrl.register_mode_select ? 16'h0000 :
                           (stat[ch].latch_view_ack ? latch_val : pos);
    end
  endgenerate

  // status travels back in the input image two cycles after the exchange starts
  pwc_image_t next_in_img;
  always_comb begin
    next_in_img = '0;
    if (!link.out_only) begin
      for (int c = 0; c < 2; c++) begin
        next_in_img[8*ctrl_off[c] +: 8] = stat[c];
        next_in_img[8*data_off[c] +: 16] = in_word[c];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link.in_img <= '0;
      link.in_done <= 1'b0;
    end else begin
      link.in_done <= xfer_d;
      if (xfer_d) begin
        link.in_img <= next_in_img;
      end
    end
  end

endmodule // pwc_unit

// >>> tb/pwc_checker.sv
// pwc_checker: assertions on the process image between coupler and unit
// assumes: instantiated beside pwc_if in the bench, one clock, reset async high
`timescale 1ns/1ps
module pwc_checker import pwc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // process image
  input wire logic xfer,
  input wire logic word_align,
  input wire logic out_only,
  input wire pwc_image_t out_img,
  input wire pwc_image_t in_img,
  input wire logic in_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // channel two moves with the alignment, channel one never does
  wire [7:0] ctl1 = out_img[7:0];
  wire [7:0] ctl2 = word_align ? out_img[39:32] : out_img[31:24];
  wire [7:0] st1 = in_img[7:0];
  wire [7:0] st2 = word_align ? in_img[39:32] : in_img[31:24];
  wire pd1 = in_done && !out_only && !ctl1[7];
  wire pd2 = in_done && !out_only && !ctl2[7];

  a_answer_next: assert property (xfer |-> ##2 in_done)
    else $error("no answer two cycles after exchange start");
  a_answer_cause: assert property (in_done |-> $past(xfer, 2))
    else $error("answer without exchange start");
  a_exchange_gap: assert property (xfer |=> !xfer [*8])
    else $error("exchanges too close together");
  a_image_held: assert property (!xfer |-> $stable(out_img))
    else $error("output image changed between exchanges");
  a_output_only: assert property (in_done && out_only |-> in_img == '0)
    else $error("input image not empty in output-only form");
  a_reg_status: assert property (in_done && !out_only && ctl1[7] |-> st1 == 8'h80)
    else $error("register mode status wrong");
  a_mode_ack: assert property (pd1 |-> !st1[7])
    else $error("process data mode not acknowledged");
  a_ready_one: assert property (pd1 |-> st1[4] == (ctl1[5] && !st1[6]))
    else $error("channel one ready wrong");
  a_ready_two: assert property (pd2 |-> st2[4] == (ctl2[5] && !st2[6]))
    else $error("channel two ready wrong");
  a_view_ack: assert property (pd1 |-> st1[3] == (ctl1[5] && ctl1[4] && st1[2]))
    else $error("latch view acknowledge wrong");
  a_preset_drop: assert property (pd1 && !ctl1[1] |-> !st1[1])
    else $error("preset done without strobe");
  a_packed_pad: assert property (in_done && !word_align |-> in_img[63:48] == 16'h0000)
    else $error("packed image padding not zero");

  c_reg_mode: cover property (in_done && ctl1[7]);
  c_latch_view: cover property (pd1 && st1[3]);
  c_out_only: cover property (in_done && out_only);
  c_aligned: cover property (in_done && word_align);
endmodule // pwc_checker

// >>> tb/pwc_current_process_interface_bench.sv
// pwc_current_process_interface_bench: coupler and unit joined, software side over Avalon
// assumes: pwc_pkg, pwc_if, both ends and the checker compiled first; 125 MHz clock
`timescale 1ns/1ps
module pwc_current_process_interface_bench import pwc_pkg::*; ;
  `include "pwc_cfg.svh"
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] latch_pin = 2'h0, aux_pin = 2'h0, fault_pin = 2'h0, warn_pin = 2'h0;
  logic [1:0] pos_step = 2'h0, pos_dir = 2'h3;
  logic [1:0][15:0] preset = '0;
  logic [15:0] max_cur = 16'h03e8;
  logic feat = 1'b0;
  logic signed [1:0][16:0] current_cmd;
  logic [1:0] channel_on, dither_active;
  logic [31:0] rd;
  int fails = 0, compares = 0;
  localparam logic [15:0] CW [3] = '{16'h7fff, 16'h4000, 16'h0000};
  localparam logic [16:0] CE [3] = '{17'h003e8, 17'h001f4, 17'h00000};

  pwc_if link();
  pwc_coupler u_pwc_coupler(.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
  pwc_unit u_pwc_unit(.clk(clk), .reset(reset), .link(link), .latch_pin(latch_pin), .aux_pin(aux_pin),
    .fault_pin(fault_pin), .warn_pin(warn_pin), .pos_step(pos_step), .pos_dir(pos_dir),
    .position_preset_register(preset), .max_current_setting(max_cur), .dither_feature_bit(feat),
    .current_cmd(current_cmd), .channel_on(channel_on), .dither_active(dither_active));
  pwc_checker u_pwc_checker(.clk(clk), .reset(reset), .xfer(link.xfer), .word_align(link.word_align),
    .out_only(link.out_only), .out_img(link.out_img), .in_img(link.in_img), .in_done(link.in_done));

  always #4 clk = ~clk;

  task print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one edge passes first so a released strobe is never raised in the same step
  task av(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 64) begin
      fails++;
      print_verdict();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    av(1'b1, a, d);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // two answers guarantee one whole exchange after the last write
  task xchg;
    int n, k;
    k = 0;
    for (n = 0; n < 4000 && k < 2; n++) begin
      @(posedge clk);
      if (link.in_done === 1'b1) k++;
    end
    if (k < 2) begin
      fails++;
      print_verdict();
    end
    repeat (2) @(posedge clk);
  endtask

  task step;
    @(posedge clk);
    pos_step <= 2'h1;
    @(posedge clk);
    pos_step <= 2'h0;
  endtask

  task pin(input logic [1:0] v);
    @(posedge clk);
    latch_pin <= v;
  endtask

  task t_enable;
    wr(`PWC_REG_CFG, 32'h4);
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h00);
    chk({30'h0, channel_on}, 32'h0);
    @(posedge clk);
    aux_pin <= 2'h1;
    wr(`PWC_REG_CTRL1, 32'h20);
    wr(`PWC_REG_CTRL2, 32'h20);
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h11);
    rdchk(`PWC_REG_STAT2, 32'h10);
    chk({24'h0, link.out_img[31:24]}, 32'h20);
    chk({30'h0, channel_on}, 32'h3);
    $display("test enable done");
  endtask

  task t_current;
    logic [15:0] nw;
    logic [16:0] ne;
    for (int i = 0; i < 3; i++) begin
      nw = -CW[i];
      ne = -CE[i];
      wr(`PWC_REG_OUT1, {16'h0, CW[i]});
      wr(`PWC_REG_OUT2, {16'h0, nw});
      xchg();
      chk({15'h0, current_cmd[0]}, {15'h0, CE[i]});
      chk({15'h0, current_cmd[1]}, {15'h0, ne});
    end
    // high byte lane off: only 0x00ff arrives
    avs_byteenable <= 4'h1;
    wr(`PWC_REG_OUT1, 32'h7fff);
    avs_byteenable <= 4'hf;
    xchg();
    chk({15'h0, current_cmd[0]}, 32'h7);
    $display("test current done");
  endtask

  task t_error;
    @(posedge clk);
    fault_pin <= 2'h1;
    warn_pin <= 2'h1;
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h61);
    @(posedge clk);
    fault_pin <= 2'h0;
    warn_pin <= 2'h0;
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h41);
    wr(`PWC_REG_CTRL1, 32'h60);
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h11);
    $display("test error done");
  endtask

  task t_preset;
    @(posedge clk);
    preset <= {16'h0000, 16'h1234};
    wr(`PWC_REG_CTRL1, 32'h22);
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h13);
    rdchk(`PWC_REG_IN1, 32'h1234);
    repeat (3) step();
    wr(`PWC_REG_CTRL1, 32'h20);
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h11);
    rdchk(`PWC_REG_IN1, 32'h1237);
    $display("test preset done");
  endtask

  task t_latch;
    pin(2'h1);
    wr(`PWC_REG_CTRL1, 32'h2c);
    xchg();
    pin(2'h0);
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h11);
    step();
    pin(2'h1);
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h15);
    wr(`PWC_REG_CTRL1, 32'h3c);
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h1d);
    rdchk(`PWC_REG_IN1, 32'h1238);
    wr(`PWC_REG_CTRL1, 32'h20);
    xchg();
    wr(`PWC_REG_CTRL1, 32'h28);
    xchg();
    step();
    pin(2'h0);
    xchg();
    wr(`PWC_REG_CTRL1, 32'h38);
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h1d);
    rdchk(`PWC_REG_IN1, 32'h1239);
    $display("test latch done");
  endtask

  task t_modes;
    wr(`PWC_REG_CTRL1, 32'h21);
    xchg();
    chk({30'h0, dither_active}, 32'h0);
    @(posedge clk);
    feat <= 1'b1;
    xchg();
    chk({30'h0, dither_active}, 32'h1);
    wr(`PWC_REG_CTRL1, 32'ha0);
    xchg();
    rdchk(`PWC_REG_STAT1, 32'h80);
    rdchk(`PWC_REG_IN1, 32'h0);
    chk({30'h0, channel_on}, 32'h2);
    wr(`PWC_REG_CTRL1, 32'h20);
    $display("test modes done");
  endtask

  task t_image;
    wr(`PWC_REG_CFG, 32'h5);
    xchg();
    chk({24'h0, link.out_img[39:32]}, 32'h20);
    chk({24'h0, link.in_img[39:32]}, 32'h10);
    rdchk(`PWC_REG_STAT1, 32'h11);
    rdchk(`PWC_REG_IN2, 32'h0);
    wr(`PWC_REG_CFG, 32'h6);
    xchg();
    chk({31'h0, link.in_img === 64'h0}, 32'h1);
    chk({24'h0, link.out_img[7:0]}, 32'h20);
    chk({30'h0, channel_on}, 32'h3);
    $display("test image done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_enable();
    t_current();
    t_error();
    t_preset();
    t_latch();
    t_modes();
    t_image();
    print_verdict();
  end
endmodule // pwc_current_process_interface_bench
